/* File: core/ism_cfg.svh */
// offsets, field positions, reset values and timing counts of the monitor
`ifndef ISM_CFG_SVH
`define ISM_CFG_SVH

// clock and time figures
`define ISM_CLK_HZ        40000000
`define ISM_HOLD_MS       1000
`define ISM_REFRESH_US    1000
`define ISM_HOLD_CYC      (`ISM_HOLD_MS * (`ISM_CLK_HZ / 1000))
`define ISM_REFRESH_CYC   (`ISM_REFRESH_US * (`ISM_CLK_HZ / 1000000))

// register byte offsets
`define ISM_OFS_CTRL      8'h00
`define ISM_OFS_RES       8'h04
`define ISM_OFS_SPD       8'h08
`define ISM_OFS_STAT      8'h0C
`define ISM_OFS_SEGS      8'h10
`define ISM_OFS_LIMIT     8'h14

// field positions
`define ISM_CTRL_LIMSEL   0
`define ISM_STAT_ITEM_LO  0
`define ISM_STAT_CONTENT  4
`define ISM_STAT_BUSY     5
`define ISM_SEGS_BOT_LO   8

// reset values
`define ISM_RES_RST       16'h0800
`define ISM_SPD_RST       16'h1388
`define ISM_LIMSEL_RST    1'b0

// monitor item codes
`define ISM_ITEM_LIMIT    2'h0
`define ISM_ITEM_HALL     2'h1
`define ISM_ITEM_INPUT    2'h2
`define ISM_ITEM_OUTPUT   2'h3

// product of speed and resolution that the pulse output can carry
`define ISM_LIMIT_K       32'h05F5E100

`endif

/* File: core/ism_pkg.sv */
// types shared by the io status segment monitor
package ism_pkg;
  typedef enum logic {
    VIEW_SELECT,
    VIEW_CONTENT
  } ism_view_t;
  typedef logic [1:0] ism_item_t;
endpackage

/* File: core/ism_hold_det.sv */
// long-press detector: one pulse when a key has been held for HOLD_CYC cycles
`timescale 1ns/1ps
`default_nettype none
module ism_hold_det #(
  parameter int unsigned HOLD_CYC = 40000000
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // key level and hold pulse
  input  wire logic i_key,
  output logic      o_hold
);
  localparam int unsigned CW = $clog2(HOLD_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(HOLD_CYC - 1);

  logic [CW-1:0] cnt_ff;
  logic          done_ff;

  // counter saturates so a key kept down fires only once
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else if (!i_key) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else if (!done_ff) begin
      if (cnt_ff == LAST) begin
        done_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  assign o_hold = i_key && !done_ff && (cnt_ff == LAST);
endmodule // ism_hold_det
`default_nettype wire

/* File: core/ism_divider.sv */
// restoring divider, one quotient bit per cycle, saturating result
`timescale 1ns/1ps
`default_nettype none
module ism_divider #(
  parameter int unsigned NW = 32,
  parameter int unsigned DW = 16
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_reset_n,
  // request
  input  wire logic          i_start,
  input  wire logic [NW-1:0] i_num,
  input  wire logic [DW-1:0] i_den,
  // result
  output logic [DW-1:0]      o_quot,
  output logic               o_busy
);
  localparam int unsigned SW = $clog2(NW + 1);

  logic [NW-1:0] rem_ff;
  logic [NW-1:0] quo_ff;
  logic [NW-1:0] num_ff;
  logic [DW-1:0] den_ff;
  logic [SW-1:0] step_ff;
  logic [NW-1:0] trial;

  assign trial = {rem_ff[NW-2:0], num_ff[NW-1]};

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rem_ff  <= '0;
      quo_ff  <= '0;
      num_ff  <= '0;
      den_ff  <= '0;
      step_ff <= '0;
      o_busy  <= 1'b0;
      o_quot  <= '0;
    end else if (i_start && !o_busy) begin
      rem_ff  <= '0;
      quo_ff  <= '0;
      num_ff  <= i_num;
      den_ff  <= i_den;
      step_ff <= SW'(NW);
      o_busy  <= 1'b1;
    end else if (o_busy) begin
      if (step_ff == '0) begin
        o_busy <= 1'b0;
        // zero divisor or oversize quotient shows the top of the range
        if (den_ff == '0 || quo_ff[NW-1:DW] != '0) begin
          o_quot <= '1;
        end else begin
          o_quot <= quo_ff[DW-1:0];
        end
      end else begin
        step_ff <= step_ff - 1'b1;
        num_ff  <= {num_ff[NW-2:0], 1'b0};
        if (trial >= NW'(den_ff)) begin
          rem_ff <= trial - NW'(den_ff);
          quo_ff <= {quo_ff[NW-2:0], 1'b1};
        end else begin
          rem_ff <= trial;
          quo_ff <= {quo_ff[NW-2:0], 1'b0};
        end
      end
    end
  end
endmodule // ism_divider
`default_nettype wire

/* File: core/ism_monitor.sv */
// panel monitor: limit, hall and i/o status items on the segment display
//
// How it works
// - one-second data key hold returns to selection
// - limit monitor derives each setting from other
// - select 0 shows allowable encoder output resolution
// - select 1 shows allowable maximum speed mm/s
// - hall item shows present hall sensor pattern
// - status items show live sampled signal state
// - input OFF lights top segment
// - input ON lights bottom segment
// - output OFF lights top segment
// - output ON lights bottom segment
// - input positions follow factory input order
// - output positions one to seven, eight reserved
// - transistor conducting ON, not conducting OFF
`include "ism_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ism_monitor #(
  parameter int unsigned HOLD_CYC    = `ISM_HOLD_CYC,
  parameter int unsigned REFRESH_CYC = `ISM_REFRESH_CYC,
  parameter int unsigned IN_N        = 8,
  parameter int unsigned OUT_N       = 7,
  parameter int unsigned POS_N       = 8,
  parameter int unsigned HALL_N      = 3
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  // wishbone slave
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [7:0]        i_wb_adr,
  input  wire logic [3:0]        i_wb_sel,
  input  wire logic [31:0]       i_wb_dat,
  output logic [31:0]            o_wb_dat,
  output logic                   o_wb_ack,
  // panel keys, high while pressed
  input  wire logic              i_key_up,
  input  wire logic              i_key_down,
  input  wire logic              i_key_data,
  // sequence inputs, high while the contact is shorted
  input  wire logic [IN_N-1:0]   i_in_closed,
  // sequence outputs, high while the transistor conducts
  input  wire logic [OUT_N-1:0]  i_out_conducting,
  // hall sensor levels
  input  wire logic [HALL_N-1:0] i_hall,
  // display
  output logic                   o_disp_content,
  output logic [1:0]             o_disp_item,
  output logic [POS_N-1:0]       o_seg_top,
  output logic [POS_N-1:0]       o_seg_bot,
  output logic [15:0]            o_disp_value
);
  localparam int unsigned RW = $clog2(REFRESH_CYC + 1);
  localparam logic [RW-1:0] REF_LAST = RW'(REFRESH_CYC - 1);

  // lit segment pair {bottom, top} for a signal that is on or off
  function automatic logic [1:0] seg_pair(input logic on);
    seg_pair = on ? 2'b10 : 2'b01;
  endfunction

  // registers
  logic                   limsel_ff;
  logic [15:0]            res_ff;
  logic [15:0]            spd_ff;
  ism_pkg::ism_view_t     view_ff;
  ism_pkg::ism_item_t     item_ff;
  logic                   up_ff;
  logic                   down_ff;
  logic [RW-1:0]          ref_cnt_ff;
  logic                   ref_tick_ff;
  logic [IN_N-1:0]        in_smp_ff;
  logic [OUT_N-1:0]       out_smp_ff;
  logic [HALL_N-1:0]      hall_smp_ff;
  logic [31:0]            nxt_rd;

  // internal nets
  logic                   data_hold;
  logic                   up_press;
  logic                   down_press;
  logic                   wb_req;
  logic                   wb_wr;
  logic [15:0]            div_quot;
  logic                   div_busy;
  logic [15:0]            div_den;
  logic [POS_N-1:0]       in_top;
  logic [POS_N-1:0]       in_bot;
  logic [POS_N-1:0]       out_top;
  logic [POS_N-1:0]       out_bot;
  logic [POS_N-1:0]       hall_top;
  logic [POS_N-1:0]       hall_bot;
  logic [POS_N-1:0]       nxt_top;
  logic [POS_N-1:0]       nxt_bot;

  // merge one 16-bit register with the enabled byte lanes
  function automatic logic [15:0] lane_wr(input logic [15:0] cur,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    lane_wr = cur;
    if (sel[0]) begin
      lane_wr[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      lane_wr[15:8] = dat[15:8];
    end
  endfunction

  // ---------------- wishbone slave ----------------
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wb_wr  = wb_req && i_wb_we;

  // every access, mapped or not, is acknowledged one cycle later
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= wb_req;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_wb_dat <= 32'h00000000;
    end else if (wb_req && !i_wb_we) begin
      o_wb_dat <= nxt_rd;
    end
  end

  always_comb begin
    nxt_rd = 32'h00000000;
    case (i_wb_adr)
      `ISM_OFS_CTRL: begin
        nxt_rd[`ISM_CTRL_LIMSEL] = limsel_ff;
      end
      `ISM_OFS_RES: begin
        nxt_rd[15:0] = res_ff;
      end
      `ISM_OFS_SPD: begin
        nxt_rd[15:0] = spd_ff;
      end
      `ISM_OFS_STAT: begin
        nxt_rd[`ISM_STAT_ITEM_LO +: 2] = item_ff;
        nxt_rd[`ISM_STAT_CONTENT] = (view_ff == ism_pkg::VIEW_CONTENT);
        nxt_rd[`ISM_STAT_BUSY] = div_busy;
      end
      `ISM_OFS_SEGS: begin
        nxt_rd[POS_N-1:0] = o_seg_top;
        nxt_rd[`ISM_SEGS_BOT_LO +: POS_N] = o_seg_bot;
      end
      `ISM_OFS_LIMIT: begin
        nxt_rd[15:0] = div_quot;
      end
      default: begin
        nxt_rd = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      limsel_ff <= `ISM_LIMSEL_RST;
    end else if (wb_wr && i_wb_adr == `ISM_OFS_CTRL && i_wb_sel[0]) begin
      limsel_ff <= i_wb_dat[`ISM_CTRL_LIMSEL];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      res_ff <= `ISM_RES_RST;
    end else if (wb_wr && i_wb_adr == `ISM_OFS_RES) begin
      res_ff <= lane_wr(res_ff, i_wb_dat, i_wb_sel);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      spd_ff <= `ISM_SPD_RST;
    end else if (wb_wr && i_wb_adr == `ISM_OFS_SPD) begin
      spd_ff <= lane_wr(spd_ff, i_wb_dat, i_wb_sel);
    end
  end

  // ---------------- panel keys ----------------
  ism_hold_det #(
    .HOLD_CYC (HOLD_CYC)
  ) u_hold (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_key     (i_key_data),
    .o_hold    (data_hold)
  );

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      up_ff   <= 1'b0;
      down_ff <= 1'b0;
    end else begin
      up_ff   <= i_key_up;
      down_ff <= i_key_down;
    end
  end

  assign up_press   = i_key_up && !up_ff;
  assign down_press = i_key_down && !down_ff;

  // long data press toggles between number selection and content
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      view_ff <= ism_pkg::VIEW_SELECT;
    end else begin
      case (view_ff)
        ism_pkg::VIEW_SELECT: begin
          if (data_hold) begin
            view_ff <= ism_pkg::VIEW_CONTENT;
          end
        end
        ism_pkg::VIEW_CONTENT: begin
          if (data_hold) begin
            view_ff <= ism_pkg::VIEW_SELECT;
          end
        end
        default: begin
          view_ff <= ism_pkg::VIEW_SELECT;
        end
      endcase
    end
  end

  // item number only moves while the selection is shown
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      item_ff <= `ISM_ITEM_LIMIT;
    end else if (view_ff == ism_pkg::VIEW_SELECT) begin
      if (up_press && !down_press) begin
        item_ff <= item_ff + 2'h1;
      end else if (down_press && !up_press) begin
        item_ff <= item_ff - 2'h1;
      end
    end
  end

  // ---------------- refresh and sampling ----------------
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ref_cnt_ff  <= '0;
      ref_tick_ff <= 1'b0;
    end else if (ref_cnt_ff == REF_LAST) begin
      ref_cnt_ff  <= '0;
      ref_tick_ff <= 1'b1;
    end else begin
      ref_cnt_ff  <= ref_cnt_ff + 1'b1;
      ref_tick_ff <= 1'b0;
    end
  end

  // fresh levels each period, never held past the next tick
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      in_smp_ff   <= '0;
      out_smp_ff  <= '0;
      hall_smp_ff <= '0;
    end else if (ref_tick_ff) begin
      in_smp_ff   <= i_in_closed;
      out_smp_ff  <= i_out_conducting;
      hall_smp_ff <= i_hall;
    end
  end

  // ---------------- limit monitor ----------------
  // one setting divides the pulse-rate constant to give the other
  assign div_den = limsel_ff ? res_ff : spd_ff;

  ism_divider #(
    .NW (32),
    .DW (16)
  ) u_div (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_start   (ref_tick_ff),
    .i_num     (`ISM_LIMIT_K),
    .i_den     (div_den),
    .o_quot    (div_quot),
    .o_busy    (div_busy)
  );

  // ---------------- segment patterns ----------------
  genvar p;
  generate
    for (p = 0; p < POS_N; p++) begin : g_pos
      // position p+1 carries signal index p in factory order
      if (p < IN_N) begin : g_in
        assign {in_bot[p], in_top[p]} = seg_pair(in_smp_ff[p]);
      end else begin : g_in_none
        assign {in_bot[p], in_top[p]} = 2'b00;
      end
      if (p < OUT_N) begin : g_out
        assign {out_bot[p], out_top[p]} = seg_pair(out_smp_ff[p]);
      end else begin : g_out_none
        // reserved position stays dark
        assign {out_bot[p], out_top[p]} = 2'b00;
      end
      if (p < HALL_N) begin : g_hall
        assign {hall_bot[p], hall_top[p]} = seg_pair(hall_smp_ff[p]);
      end else begin : g_hall_none
        assign {hall_bot[p], hall_top[p]} = 2'b00;
      end
    end
  endgenerate

  always_comb begin
    nxt_top = '0;
    nxt_bot = '0;
    if (view_ff == ism_pkg::VIEW_CONTENT) begin
      case (item_ff)
        `ISM_ITEM_HALL: begin
          nxt_top = hall_top;
          nxt_bot = hall_bot;
        end
        `ISM_ITEM_INPUT: begin
          nxt_top = in_top;
          nxt_bot = in_bot;
        end
        `ISM_ITEM_OUTPUT: begin
          nxt_top = out_top;
          nxt_bot = out_bot;
        end
        default: begin
          nxt_top = '0;
          nxt_bot = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_seg_top <= '0;
      o_seg_bot <= '0;
    end else begin
      o_seg_top <= nxt_top;
      o_seg_bot <= nxt_bot;
    end
  end

  // number shown: item number while selecting, limit value for the limit item in content, zero for other content items
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_disp_value <= 16'h0000;
    end else if (view_ff == ism_pkg::VIEW_CONTENT
                 && item_ff == `ISM_ITEM_LIMIT) begin
      o_disp_value <= div_quot;
    end else if (view_ff == ism_pkg::VIEW_CONTENT) begin
      o_disp_value <= 16'h0000;
    end else begin
      o_disp_value <= {14'h0000, item_ff};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_disp_content <= 1'b0;
      o_disp_item    <= `ISM_ITEM_LIMIT;
    end else begin
      o_disp_content <= (view_ff == ism_pkg::VIEW_CONTENT);
      o_disp_item    <= item_ff;
    end
  end
endmodule // ism_monitor
`default_nettype wire

/* File: tb/ism_monitor_checker.sv */
// port-level assertions for the io status segment monitor
`timescale 1ns/1ps
`default_nettype none
module ism_monitor_checker #(
  parameter int unsigned HOLD_CYC    = 20,
  parameter int unsigned REFRESH_CYC = 16
) (
  // clock, reset and bus handshake
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_wb_cyc,
  input wire logic       i_wb_stb,
  input wire logic       o_wb_ack,
  // keys and monitored signals
  input wire logic       i_key_up,
  input wire logic       i_key_down,
  input wire logic       i_key_data,
  input wire logic [7:0] i_in_closed,
  input wire logic [6:0] i_out_conducting,
  input wire logic [2:0] i_hall,
  // display
  input wire logic       o_disp_content,
  input wire logic [1:0] o_disp_item,
  input wire logic [7:0] o_seg_top,
  input wire logic [7:0] o_seg_bot
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  int unsigned stab_ff;
  int unsigned key_ff;
  logic        settled;
  // settled only once a sample has been taken after the last change
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !($stable(i_in_closed) && $stable(i_out_conducting) && $stable(i_hall)
        && $stable(o_disp_content) && $stable(o_disp_item))) begin
      stab_ff <= 0;
    end else if (stab_ff < REFRESH_CYC + 4) begin
      stab_ff <= stab_ff + 1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !i_key_data) begin
      key_ff <= 0;
    end else if (key_ff < HOLD_CYC) begin
      key_ff <= key_ff + 1;
    end
  end
  assign settled = stab_ff >= REFRESH_CYC + 4;

  chk_ack_pulse: assert property (
    o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
  chk_ack_answer: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("request not answered");
  chk_in_map: assert property (
    settled && o_disp_content && o_disp_item == 2'h2
    |-> o_seg_bot == i_in_closed && o_seg_top == ~i_in_closed) else $error("input segments");
  chk_out_map: assert property (
    settled && o_disp_content && o_disp_item == 2'h3
    |-> o_seg_bot == {1'b0, i_out_conducting} && o_seg_top == {1'b0, ~i_out_conducting})
    else $error("output segments");
  chk_hall_map: assert property (
    settled && o_disp_content && o_disp_item == 2'h1
    |-> o_seg_bot == {5'h00, i_hall} && o_seg_top == {5'h00, ~i_hall}) else $error("hall segments");
  chk_dark_view: assert property (
    settled && (!o_disp_content || o_disp_item == 2'h0)
    |-> o_seg_top == 8'h00 && o_seg_bot == 8'h00) else $error("segments not dark");
  chk_hold_toggle: assert property (
    i_key_data && key_ff == HOLD_CYC - 1
    |-> ##2 o_disp_content != $past(o_disp_content, 2)) else $error("hold did not toggle view");
  chk_no_stray: assert property (
    $changed(o_disp_content) |-> $past(key_ff, 2) == HOLD_CYC - 1 && $past(i_key_data, 2))
    else $error("view changed without hold");
  chk_item_step: assert property (
    !o_disp_content && i_key_up && !$past(i_key_up) && !i_key_down
    |-> ##2 o_disp_item == $past(o_disp_item, 2) + 2'h1) else $error("item did not step");
endmodule // ism_monitor_checker

bind ism_monitor ism_monitor_checker #(.HOLD_CYC(HOLD_CYC), .REFRESH_CYC(REFRESH_CYC))
  ism_monitor_checker_i (.i_clk, .i_reset_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .i_key_up,
  .i_key_down, .i_key_data, .i_in_closed, .i_out_conducting, .i_hall, .o_disp_content,
  .o_disp_item, .o_seg_top, .o_seg_bot);
`default_nettype wire

/* File: tb/ism_panel_model.sv */
// panel keys and sequence terminal contacts facing the monitor
`timescale 1ns/1ps
`default_nettype none
module ism_panel_model (
  // clock
  input wire logic  i_clk,
  // keys, contacts, transistors and hall levels
  output logic       o_key_up,
  output logic       o_key_down,
  output logic       o_key_data,
  output logic [7:0] o_in_closed,
  output logic [6:0] o_out_conducting,
  output logic [2:0] o_hall
);
  initial begin
    {o_key_up, o_key_down, o_key_data} = 3'h0;
    {o_in_closed, o_out_conducting, o_hall} = 18'h00000;
  end
  // clean levels: the block has no debounce, bounce is not modelled
  task automatic press(input int k, input int n);
    @(posedge i_clk);
    if (k == 0) o_key_up <= 1'b1;
    else if (k == 1) o_key_down <= 1'b1;
    else o_key_data <= 1'b1;
    repeat (n) @(posedge i_clk);
    {o_key_up, o_key_down, o_key_data} <= 3'h0;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic drive(input logic [7:0] ci, input logic [6:0] co, input logic [2:0] h);
    @(posedge i_clk);
    o_in_closed <= ci; // shorted contact is 1
    o_out_conducting <= co; // conducting transistor is 1
    o_hall <= h;
  endtask
endmodule // ism_panel_model
`default_nettype wire

/* File: tb/test_io_status_segment_monitor.sv */
// self-checking bench for the io status segment monitor
`timescale 1ns/1ps
`default_nettype none
module test_io_status_segment_monitor;
  localparam int HOLD = 20;
  localparam int REFR = 16;
  logic        clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        k_up;
  logic        k_dn;
  logic        k_dat;
  logic [7:0]  cin;
  logic [6:0]  cout;
  logic [2:0]  hall;
  logic        content;
  logic [1:0]  item;
  logic [7:0]  top;
  logic [7:0]  bot;
  logic [15:0] val;
  logic [31:0] q;
  int          n_mismatch;
  int          n_tests;
  int          i;
  logic [7:0]  ip [5] = '{8'h01, 8'h80, 8'hA5, 8'h00, 8'hFF};
  logic [6:0]  op [4] = '{7'h01, 7'h40, 7'h7F, 7'h00};

  ism_monitor #(.HOLD_CYC(HOLD), .REFRESH_CYC(REFR)) ism_monitor_i (
    .i_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_key_up(k_up), .i_key_down(k_dn), .i_key_data(k_dat), .i_in_closed(cin),
    .i_out_conducting(cout), .i_hall(hall), .o_disp_content(content), .o_disp_item(item),
    .o_seg_top(top), .o_seg_bot(bot), .o_disp_value(val));
  ism_panel_model ism_panel_model_i (
    .i_clk(clk), .o_key_up(k_up), .o_key_down(k_dn), .o_key_data(k_dat),
    .o_in_closed(cin), .o_out_conducting(cout), .o_hall(hall));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d, compares %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one classic cycle, held until ack is sampled; read data lands in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
    if (k == 20) begin
      n_mismatch++;
      close_out();
    end
  endtask

  task automatic seg_is(input logic [7:0] t, input logic [7:0] b);
    for (i = 0; i < 80 && !(top === t && bot === b); i++) @(posedge clk);
    chk(32'(top), 32'(t), "top segments");
    chk(32'(bot), 32'(b), "bottom segments");
    if (i == 80) close_out();
  endtask

  // the limit divider skips refresh ticks while busy, so allow several
  task automatic val_is(input logic [15:0] v);
    for (i = 0; i < 120 && val !== v; i++) @(posedge clk);
    chk(32'(val), 32'(v), "display value");
    if (i == 120) close_out();
  endtask

  task automatic hold();
    ism_panel_model_i.press(2, HOLD + 2);
  endtask

  initial begin
    {rst_n, cyc, stb, we, adr, sel, wdat} = 48'h0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'({top, bot, val}), 32'h0, "outputs after reset");
    chk(32'({content, item}), 32'h0, "view after start");
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0800, "resolution reset");
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h1388, "speed reset");
    wb(1'b1, 8'h20, 32'h1234);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0, "unmapped read");
    wb(1'b1, 8'h0C, 32'hFFFF);
    wb(1'b0, 8'h0C, 32'h0);
    chk(q & 32'hFFDF, 32'h0, "status read only");
    hold();
    chk(32'(content), 32'h1, "content view");
    val_is(16'h4E20);
    wb(1'b1, 8'h00, 32'h1);
    val_is(16'hBEBC);
    wb(1'b1, 8'h04, 32'h0);
    val_is(16'hFFFF);
    wb(1'b0, 8'h14, 32'h0);
    chk(q, 32'hFFFF, "limit register");
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h08, 32'h2710);
    val_is(16'h2710);
    hold();
    chk(32'({content, val}), 32'h0, "back to selection");
    ism_panel_model_i.press(0, 1);
    chk(32'(item), 32'h1, "item after up");
    ism_panel_model_i.drive(8'h00, 7'h00, 3'b101);
    hold();
    seg_is(8'h02, 8'h05);
    ism_panel_model_i.drive(8'h00, 7'h00, 3'b010);
    seg_is(8'h05, 8'h02);
    chk(32'(val), 32'h0, "value in hall view");
    hold();
    ism_panel_model_i.press(0, 1);
    hold();
    wb(1'b0, 8'h0C, 32'h0);
    chk(q & 32'h13, 32'h12, "status item");
    ism_panel_model_i.press(0, 1);
    chk(32'(item), 32'h2, "item held in content");
    foreach (ip[n]) begin
      ism_panel_model_i.drive(ip[n], 7'h55, 3'h0);
      seg_is(~ip[n], ip[n]);
    end
    hold();
    ism_panel_model_i.press(0, 1);
    hold();
    foreach (op[n]) begin
      ism_panel_model_i.drive(8'hAA, op[n], 3'h7);
      seg_is({1'b0, ~op[n]}, {1'b0, op[n]});
    end
    hold();
    ism_panel_model_i.press(0, 1);
    chk(32'(item), 32'h0, "item wrap");
    ism_panel_model_i.press(1, 1);
    chk(32'(item), 32'h3, "item after down");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'({content, item}), 32'h0, "view after reset");
    close_out();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
endmodule // test_io_status_segment_monitor
`default_nettype wire
